// ---- cam_config.v ----
/*
 * Counter array mode and configuration: mode register with watchdog
 * enable, lock and write protection, timebase selection, idle suspend,
 * 16-bit counter with overflow flag and interrupt request, and the
 * capture/compare versus auto-reload bank steering at module addresses.
 * Assumes a single-cycle special function register bus on clk, a run
 * control and flag clear from the neighbouring control register, and
 * asynchronous counter and external clock pins.
 */
// Behaviour
// RQ1 - idle bit 0: count normally during idle
// RQ2 - idle bit 1: suspend everything during idle
// RQ3 - watchdog enable hands module 2 to watchdog
// RQ4 - lock forces watchdog enable until reset
// RQ5 - timebase: div12, div4, timer0, sysclk; 11x reserved
// RQ6 - code 011 counts counter-input falling edges
// RQ7 - code 101 counts synced external clock div8
// RQ8 - overflow interrupt request gated by enable bit
// RQ9 - watchdog enabled blocks other mode bit writes
// RQ10 - mode bit 4 reads zero, ignores writes
// RQ11 - bank select steers module high/low accesses
// RQ12 - reload registers feed 9..16-bit PWM reload
// RQ13 - reload registers inert in other modes
// RQ14 - overflow flag set on wrap, software clears
// RQ15 - reserved timebase codes give no counts
`include "cam_regs.vh"
`default_nettype none

module cam_config #(
   parameter MODULES = 3                        // capture/compare modules
) (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst_n,
   // register bus
   input  wire [7:0]             sfr_addr,
   input  wire [7:0]             sfr_wdata,
   input  wire                   sfr_wr,
   input  wire                   sfr_rd,
   output reg  [7:0]             sfr_rdata,
   // system status and neighbouring control
   input  wire                   cpu_idle,
   input  wire                   counter_run,
   input  wire                   overflow_flag_clear,
   input  wire                   timer0_overflow,
   input  wire [MODULES-1:0]     pwm_wide_mode,
   // pins
   input  wire                   external_count_input,
   input  wire                   external_clock,
   // counter and module outputs
   output reg  [15:0]            counter_value,
   output reg                    counter_overflow_flag,
   output wire                   counter_irq,
   output wire                   watchdog_active,
   output wire                   suspended,
   output wire [16*MODULES-1:0]  compare_value,
   output reg  [16*MODULES-1:0]  reload_value
);

   // mode register fields
   reg                 idle_suspend;             // suspend during idle
   reg                 watchdog_enable;          // module 2 as watchdog
   reg                 watchdog_lock;            // sticky until reset
   reg  [2:0]          timebase_select;          // counter clock source
   reg                 overflow_irq_enable;      // overflow irq mask
   // pwm configuration register, bit 4 never stored
   reg  [7:0]          pwm_config_reg;
   // module storage, addressed by module index
   reg  [7:0]          cc_low   [0:MODULES-1];   // capture/compare low
   reg  [7:0]          cc_high  [0:MODULES-1];   // capture/compare high
   reg  [7:0]          ar_low   [0:MODULES-1];   // auto-reload low
   reg  [7:0]          ar_high  [0:MODULES-1];   // auto-reload high
   // synchronisers
   reg  [2:0]          cnt_in_sync;              // counter input pin
   reg  [2:0]          ext_sync;                 // external clock pin
   // prescalers
   reg  [3:0]          div12_cnt;
   reg  [1:0]          div4_cnt;
   reg  [2:0]          ext_div_cnt;
   // combinational
   reg                 tick;                     // selected count pulse
   reg  [7:0]          mode_read;                // assembled mode byte
   reg  [7:0]          next_rdata;
   wire                reload_bank;              // bank select bit
   wire                mode_wr;
   wire                pwm_wr;
   wire                count_en;
   wire                cnt_in_fall;
   wire                ext_rise;
   wire [3:0]          mod_dec;                  // {hit, high, index}
   wire [1:0]          mod_idx;
   integer             i;                        // storage reset loop
   integer             j;                        // reload output loop

   // decode a module low/high address into {hit, high byte, index}
   function [3:0] mod_decode;
      input [7:0] a;
      begin
         case (a)
            `CAM_ADDR_LOW0:  mod_decode = 4'h8;
            `CAM_ADDR_HIGH0: mod_decode = 4'hC;
            `CAM_ADDR_LOW1:  mod_decode = 4'h9;
            `CAM_ADDR_HIGH1: mod_decode = 4'hD;
            `CAM_ADDR_LOW2:  mod_decode = 4'hA;
            `CAM_ADDR_HIGH2: mod_decode = 4'hE;
            default:         mod_decode = 4'h0;
         endcase
      end
   endfunction

   assign mod_dec     = mod_decode(sfr_addr);
   assign mod_idx     = mod_dec[1:0];
   assign mode_wr     = sfr_wr && (sfr_addr == `CAM_ADDR_MODE);
   assign pwm_wr      = sfr_wr && (sfr_addr == `CAM_ADDR_PWM_CFG);
   assign reload_bank = pwm_config_reg[`CAM_PWM_BANK_BIT];

   // mode register; watchdog enable blocks all fields but enable and lock
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_suspend        <= 1'b0;
         watchdog_enable     <= 1'b1;
         watchdog_lock       <= 1'b0;
         timebase_select     <= 3'h0;
         overflow_irq_enable <= 1'b0;
      end else if (mode_wr) begin
         // lock only sets; once set, enable stays high
         watchdog_lock   <= watchdog_lock | sfr_wdata[`CAM_MODE_LOCK_BIT];     // RQ4
         watchdog_enable <= watchdog_lock | sfr_wdata[`CAM_MODE_LOCK_BIT]
                            | sfr_wdata[`CAM_MODE_WDE_BIT];                    // RQ4
         // other fields only move while watchdog is off
         if (!watchdog_active) begin                                          // RQ9
            idle_suspend        <= sfr_wdata[`CAM_MODE_IDLE_BIT];
            timebase_select     <= sfr_wdata[`CAM_MODE_TB_HI:`CAM_MODE_TB_LO];
            overflow_irq_enable <= sfr_wdata[`CAM_MODE_OVIE_BIT];
         end
      end
   end

   // watchdog handed module 2 while enabled or locked
   assign watchdog_active = watchdog_enable | watchdog_lock;                 // RQ3

   // pwm configuration register, unused bit 4 masked
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_config_reg <= `CAM_PWM_RESET;
      end else if (pwm_wr) begin
         pwm_config_reg <= sfr_wdata & `CAM_PWM_WMASK;                        // RQ10
      end
   end

   // module registers; bank select picks compare or reload storage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < MODULES; i = i + 1) begin
            cc_low[i]  <= 8'h00;
            cc_high[i] <= 8'h00;
            ar_low[i]  <= 8'h00;
            ar_high[i] <= 8'h00;
         end
      end else if (sfr_wr && mod_dec[3]) begin
         case ({reload_bank, mod_dec[2]})
            2'b00:   cc_low[mod_idx]  <= sfr_wdata;                           // RQ11
            2'b01:   cc_high[mod_idx] <= sfr_wdata;                           // RQ11
            2'b10:   ar_low[mod_idx]  <= sfr_wdata;                           // RQ11
            default: ar_high[mod_idx] <= sfr_wdata;                           // RQ11
         endcase
      end
   end

   // compare values straight from storage
   genvar g;
   generate
      for (g = 0; g < MODULES; g = g + 1) begin : g_cmp
         assign compare_value[16*g+15:16*g] = {cc_high[g], cc_low[g]};
      end
   endgenerate

   // reload values reach only modules in 9..16-bit pwm, else zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_value <= {16*MODULES{1'b0}};
      end else begin
         for (j = 0; j < MODULES; j = j + 1) begin
            if (pwm_wide_mode[j]) begin
               reload_value[16*j +: 16] <= {ar_high[j], ar_low[j]};           // RQ12
            end else begin
               reload_value[16*j +: 16] <= 16'h0000;                          // RQ13
            end
         end
      end
   end

   // pin synchronisers; stage 0 is read only by stage 1
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_in_sync <= 3'h7;
         ext_sync    <= 3'h0;
      end else begin
         cnt_in_sync <= {cnt_in_sync[1:0], external_count_input};
         ext_sync <= {ext_sync[1:0], external_clock};
      end
   end

   // edge detection on synchronised stages
   assign cnt_in_fall = cnt_in_sync[2] & ~cnt_in_sync[1];                    // RQ6
   assign ext_rise = ~ext_sync[2] & ext_sync[1];                             // RQ7

   // counting is suspended while idle when idle_suspend is set
   assign suspended = idle_suspend & cpu_idle;                               // RQ2
   assign count_en  = counter_run & ~suspended & tick;                       // RQ1

   // prescalers freeze with the rest of the array when suspended
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div12_cnt   <= 4'h0;
         div4_cnt    <= 2'h0;
         ext_div_cnt <= 3'h0;
      end else if (!suspended) begin                                          // RQ2
         if (div12_cnt == `CAM_DIV12_LAST) begin
            div12_cnt <= 4'h0;
         end else begin
            div12_cnt <= div12_cnt + 4'h1;
         end
         div4_cnt <= div4_cnt + 2'h1;
         if (ext_rise) begin
            ext_div_cnt <= ext_div_cnt + 3'h1;                                // RQ7
         end
      end
   end

   // timebase multiplexer; reserved codes give no pulses
   always @* begin
      case (timebase_select)
         `CAM_TB_DIV12:   tick = (div12_cnt == `CAM_DIV12_LAST);              // RQ5
         `CAM_TB_DIV4:    tick = (div4_cnt == `CAM_DIV4_LAST);                // RQ5
         `CAM_TB_T0OVF:   tick = timer0_overflow;                             // RQ5
         `CAM_TB_CNTPIN:  tick = cnt_in_fall;                                 // RQ6
         `CAM_TB_SYSCLK:  tick = 1'b1;                                        // RQ5
         `CAM_TB_EXTDIV8: tick = ext_rise && (ext_div_cnt == `CAM_EXT_DIV_LAST); // RQ7
         default:         tick = 1'b0;                                        // RQ15
      endcase
   end

   // 16-bit counter and overflow flag; a set beats a clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_value         <= 16'h0000;
         counter_overflow_flag <= 1'b0;
      end else begin
         if (count_en) begin
            counter_value <= counter_value + 16'h0001;
         end
         if (count_en && (counter_value == 16'hFFFF)) begin
            counter_overflow_flag <= 1'b1;                                    // RQ14
         end else if (overflow_flag_clear) begin
            counter_overflow_flag <= 1'b0;                                    // RQ14
         end
      end
   end

   // interrupt request masked by the enable bit
   assign counter_irq = counter_overflow_flag & overflow_irq_enable;         // RQ8

   // mode byte as read; bit 4 reads zero
   always @* begin
      mode_read = 8'h00;                                                     // RQ10
      mode_read[`CAM_MODE_IDLE_BIT]                = idle_suspend;
      mode_read[`CAM_MODE_WDE_BIT]                 = watchdog_active;
      mode_read[`CAM_MODE_LOCK_BIT]                = watchdog_lock;
      mode_read[`CAM_MODE_TB_HI:`CAM_MODE_TB_LO]   = timebase_select;
      mode_read[`CAM_MODE_OVIE_BIT]                = overflow_irq_enable;
   end

   // read multiplexer; unmapped addresses return zero
   always @* begin
      next_rdata = 8'h00;
      if (sfr_addr == `CAM_ADDR_MODE) begin
         next_rdata = mode_read;
      end else if (sfr_addr == `CAM_ADDR_PWM_CFG) begin
         next_rdata = pwm_config_reg;
      end else if (mod_dec[3]) begin
         case ({reload_bank, mod_dec[2]})
            2'b00:   next_rdata = cc_low[mod_idx];                            // RQ11
            2'b01:   next_rdata = cc_high[mod_idx];                           // RQ11
            2'b10:   next_rdata = ar_low[mod_idx];                            // RQ11
            default: next_rdata = ar_high[mod_idx];                           // RQ11
         endcase
      end
   end

   // read data registered one cycle after the strobe, held otherwise
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= next_rdata;
      end
   end

endmodule // cam_config

`default_nettype wire

// ---- cam_regs.vh ----
/*
 * Register map, field positions, reset values and timebase counts for the
 * counter array mode and configuration block.
 * Assumes an 8-bit special function register bus with byte addresses.
 */
`ifndef CAM_REGS_VH
`define CAM_REGS_VH

// register addresses
`define CAM_ADDR_MODE      8'hD9
`define CAM_ADDR_PWM_CFG   8'hF7
// module compare low/high addresses for modules 0..2
`define CAM_ADDR_LOW0      8'hFB
`define CAM_ADDR_HIGH0     8'hFC
`define CAM_ADDR_LOW1      8'hE9
`define CAM_ADDR_HIGH1     8'hEA
`define CAM_ADDR_LOW2      8'hEB
`define CAM_ADDR_HIGH2     8'hEC

// mode register fields
`define CAM_MODE_IDLE_BIT  7
`define CAM_MODE_WDE_BIT   6
`define CAM_MODE_LOCK_BIT  5
`define CAM_MODE_TB_HI     3
`define CAM_MODE_TB_LO     1
`define CAM_MODE_OVIE_BIT  0
`define CAM_MODE_RESET     8'h40

// pwm configuration fields
`define CAM_PWM_BANK_BIT   7
`define CAM_PWM_WMASK      8'hEF
`define CAM_PWM_RESET      8'h00

// timebase codes
`define CAM_TB_DIV12       3'h0
`define CAM_TB_DIV4        3'h1
`define CAM_TB_T0OVF       3'h2
`define CAM_TB_CNTPIN      3'h3
`define CAM_TB_SYSCLK      3'h4
`define CAM_TB_EXTDIV8     3'h5

// prescale terminal counts
`define CAM_DIV12_LAST     4'hB
`define CAM_DIV4_LAST      2'h3
`define CAM_EXT_DIV_LAST   3'h7

`endif

// ---- cam_config_sva.sv ----
/* checker for the counter array mode block: watchdog enable and lock,
   suspend, overflow flag and request, read-only bits, reload gating.
   assumes it is bound onto cam_config and sees only its ports */
`include "cam_regs.vh"
`default_nettype none
module cam_config_sva #(
   parameter MODULES = 3
) (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    rst_n,
   // register bus
   input wire logic [7:0]              sfr_addr,
   input wire logic [7:0]              sfr_wdata,
   input wire logic                    sfr_wr,
   input wire logic                    sfr_rd,
   input wire logic [7:0]              sfr_rdata,
   // status and controls
   input wire logic                    cpu_idle,
   input wire logic                    overflow_flag_clear,
   input wire logic [MODULES-1:0]      pwm_wide_mode,
   // outputs watched
   input wire logic [15:0]             counter_value,
   input wire logic                    counter_overflow_flag,
   input wire logic                    counter_irq,
   input wire logic                    watchdog_active,
   input wire logic                    suspended,
   input wire logic [16*MODULES-1:0]   reload_value
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a mode write, and whether a lock has been written since reset
   wire  mode_wr = sfr_wr && sfr_addr == `CAM_ADDR_MODE;
   logic locked;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) locked <= 1'b0;
      else if (mode_wr && sfr_wdata[5]) locked <= 1'b1;
   end
   property p_susp_freeze; suspended |=> $stable(counter_value); endproperty
   a_susp_freeze: assert property (p_susp_freeze) else $error("counter moved in suspend");
   property p_susp_cause; suspended |-> cpu_idle; endproperty
   a_susp_cause: assert property (p_susp_cause) else $error("suspended without idle");
   property p_irq_mask; counter_irq |-> counter_overflow_flag; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("request without flag");
   property p_wrap_flag;
      $past(counter_value) == 16'hFFFF && counter_value == 16'h0000 |-> counter_overflow_flag;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("wrap left flag clear");
   property p_flag_sticky; counter_overflow_flag && !overflow_flag_clear |=> counter_overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");
   property p_flag_rise; $rose(counter_overflow_flag) |-> counter_value == 16'h0000; endproperty
   a_flag_rise: assert property (p_flag_rise) else $error("flag set without wrap");
   property p_lock_hold; locked |-> watchdog_active; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked watchdog went off");
   property p_wde_set; mode_wr && sfr_wdata[6] |=> watchdog_active; endproperty
   a_wde_set: assert property (p_wde_set) else $error("watchdog not enabled");
   property p_wde_clr; mode_wr && sfr_wdata[6:5] == 2'h0 && !locked |=> !watchdog_active;
   endproperty
   a_wde_clr: assert property (p_wde_clr) else $error("watchdog not disabled");
   property p_bit4;
      sfr_rd && (sfr_addr == `CAM_ADDR_MODE || sfr_addr == `CAM_ADDR_PWM_CFG) |=> !sfr_rdata[4];
   endproperty
   a_bit4: assert property (p_bit4) else $error("bit 4 read as one");
   property p_reload_off; (pwm_wide_mode == '0) [*2] |-> reload_value == '0; endproperty
   a_reload_off: assert property (p_reload_off) else $error("reload outside wide pwm");
   c_wrap: cover property ($rose(counter_overflow_flag));
   c_susp: cover property (suspended);
   c_lock: cover property (locked && mode_wr);
endmodule // cam_config_sva
bind cam_config cam_config_sva #(.MODULES(MODULES)) u_sva (
   .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
   .overflow_flag_clear(overflow_flag_clear), .pwm_wide_mode(pwm_wide_mode),
   .counter_value(counter_value), .counter_overflow_flag(counter_overflow_flag),
   .counter_irq(counter_irq), .watchdog_active(watchdog_active), .suspended(suspended),
   .reload_value(reload_value));
`default_nettype wire

// ---- tb_counter_array_mode_config.sv ----
/* bench for the counter array mode block: register reads and writes,
   timebase sources, suspend, overflow, bank steering and watchdog lock.
   assumes cam_config with a one-cycle strobe register bus */
`include "cam_regs.vh"
`default_nettype none
module tb_counter_array_mode_config;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic        cpu_idle = 1'b0, counter_run = 1'b0, overflow_flag_clear = 1'b0;
   logic        timer0_overflow = 1'b0, external_count_input = 1'b1, external_clock = 1'b0;
   logic [2:0]  pwm_wide_mode = 3'h0;
   logic [15:0] counter_value, base;
   logic        counter_overflow_flag, counter_irq, watchdog_active, suspended;
   logic [47:0] compare_value, reload_value;
   int          fails = 0, n_checks = 0;
   // mode per timebase run and the count it must yield over 72 cycles
   logic [7:0]  modes [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h88};
   int          want [9] = '{6, 18, 8, 16, 72, 2, 0, 0, 0};
   always #2.5 clk = ~clk;
   cam_config #(.MODULES(3)) dut (
      .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .counter_run(counter_run),
      .overflow_flag_clear(overflow_flag_clear), .timer0_overflow(timer0_overflow),
      .pwm_wide_mode(pwm_wide_mode), .external_count_input(external_count_input),
      .external_clock(external_clock), .counter_value(counter_value),
      .counter_overflow_flag(counter_overflow_flag), .counter_irq(counter_irq),
      .watchdog_active(watchdog_active), .suspended(suspended),
      .compare_value(compare_value), .reload_value(reload_value));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
      n_checks++;
      if (got !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, got);
         fails++;
      end
   endtask
   // one-cycle write strobe, driven from the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   // one-cycle read strobe, data settled by the next falling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
   endtask
   // run 72 cycles under a mode, feeding only the selected source pin
   task automatic run(input logic [7:0] m, input logic [15:0] e);
      wr(`CAM_ADDR_MODE, m);
      base = counter_value;
      counter_run = 1'b1;
      for (int i = 0; i < 72; i++) begin
         timer0_overflow = m[3:1] == `CAM_TB_T0OVF && i % 8 == 0 && i < 64;
         external_count_input = !(m[3:1] == `CAM_TB_CNTPIN && i[1] && i < 64);
         external_clock = m[3:1] == `CAM_TB_EXTDIV8 && i[1] && i < 64;
         @(negedge clk);
      end
      counter_run = 1'b0;
      @(negedge clk);
      chk("counter delta", e, counter_value - base);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog against a hang: the whole run needs about 66000 cycles
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      close_out;
   end
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      rd(`CAM_ADDR_MODE, 8'h40);
      chk("watchdog_active", 16'h0001, 16'(watchdog_active));
      rd(`CAM_ADDR_PWM_CFG, `CAM_PWM_RESET);
      wr(`CAM_ADDR_MODE, 8'h8F);
      rd(`CAM_ADDR_MODE, 8'h00);
      chk("watchdog_active", 16'h0000, 16'(watchdog_active));
      wr(`CAM_ADDR_MODE, 8'h19);
      rd(`CAM_ADDR_MODE, 8'h09);
      // every timebase code with the cpu idle throughout
      cpu_idle = 1'b1;
      for (int k = 0; k < 9; k++) run(modes[k], 16'(want[k]));
      chk("suspended", 16'h0001, 16'(suspended));
      cpu_idle = 1'b0;
      // full-speed count up to the wrap
      wr(`CAM_ADDR_MODE, 8'h09);
      chk("suspended", 16'h0000, 16'(suspended));
      counter_run = 1'b1;
      while (counter_value !== 16'hFFFF) @(negedge clk);
      @(negedge clk);
      counter_run = 1'b0;
      chk("counter_overflow_flag", 16'h0001, 16'(counter_overflow_flag));
      chk("counter_irq", 16'h0001, 16'(counter_irq));
      wr(`CAM_ADDR_MODE, 8'h08);
      chk("counter_irq", 16'h0000, 16'(counter_irq));
      chk("counter_overflow_flag", 16'h0001, 16'(counter_overflow_flag));
      overflow_flag_clear = 1'b1;
      @(negedge clk);
      overflow_flag_clear = 1'b0;
      @(negedge clk);
      chk("counter_overflow_flag", 16'h0000, 16'(counter_overflow_flag));
      // bank steering at module 0 low
      wr(`CAM_ADDR_PWM_CFG, 8'hFF);
      rd(`CAM_ADDR_PWM_CFG, `CAM_PWM_WMASK);
      wr(`CAM_ADDR_LOW0, 8'h3C);
      pwm_wide_mode = 3'h1;
      wr(`CAM_ADDR_PWM_CFG, 8'h00);
      wr(`CAM_ADDR_LOW0, 8'hA5);
      rd(`CAM_ADDR_LOW0, 8'hA5);
      chk("compare_value", 16'h00A5, compare_value[15:0]);
      chk("reload_value", 16'h003C, reload_value[15:0]);
      pwm_wide_mode = 3'h0;
      wr(`CAM_ADDR_PWM_CFG, 8'h80);
      rd(`CAM_ADDR_LOW0, 8'h3C);
      chk("reload_value", 16'h0000, reload_value[15:0]);
      rd(8'h00, 8'h00);
      // lock, then a second reset frees the enable
      wr(`CAM_ADDR_MODE, 8'h20);
      wr(`CAM_ADDR_MODE, 8'h08);
      rd(`CAM_ADDR_MODE, 8'h60);
      chk("watchdog_active", 16'h0001, 16'(watchdog_active));
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      rd(`CAM_ADDR_MODE, 8'h40);
      wr(`CAM_ADDR_MODE, 8'h00);
      chk("watchdog_active", 16'h0000, 16'(watchdog_active));
      close_out;
   end
endmodule // tb_counter_array_mode_config
`default_nettype wire
